// ===== pkg/pmc_pkg.sv
// package with register map, field layout, reset values and timing counts for power mode control
package pmc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on apb)
    // ------------------------------------------------------------
    // the documented 87h is a word index; apb sees four times it as the byte address
    localparam logic [11:0] PMC_IDX_POWER_CONTROL = 12'h087;  // power control word index
    localparam logic [11:0] PMC_OFF_POWER_CONTROL = 12'(PMC_IDX_POWER_CONTROL * 4);  // byte addr
    localparam logic [11:0] PMC_OFF_AUX_REGISTER  = 12'h08c;  // aux register, ale off bit
    localparam logic [11:0] PMC_OFF_AUX_REGISTER1 = 12'h090;  // aux register 1
    localparam logic [11:0] PMC_OFF_EVENTS        = 12'h094;  // event inputs, write 1 pulses
    localparam logic [11:0] PMC_OFF_STATUS        = 12'h098;  // mode status, read only

    // ------------------------------------------------------------
    // power control field positions
    // ------------------------------------------------------------
    localparam int PMC_PC_BAUD_DOUBLE = 7;  // baud double
    localparam int PMC_PC_FRAME_SEL   = 6;  // serial frame select
    localparam int PMC_PC_POF         = 5;  // power off flag
    localparam int PMC_PC_WLE         = 4;  // watchdog load enable
    localparam int PMC_PC_GF1         = 3;  // general flag 1
    localparam int PMC_PC_GF0         = 2;  // general flag 0
    localparam int PMC_PC_PD          = 1;  // powerdown select
    localparam int PMC_PC_IDL         = 0;  // idle select

    // aux register fields
    localparam int PMC_AUX_ALE_OFF    = 0;  // addr latch off
    localparam int PMC_AUX1_WDE       = 4;  // watchdog enable bit
    localparam int PMC_AUX1_POWERDOWN_WAKEUP_ENABLE      = 3;  // powerdown wakeup enable

    // event register fields (write one to pulse)
    localparam int PMC_EV_WDT_LOAD    = 0;  // watchdog timer loaded

    // ------------------------------------------------------------
    // reset values; undefined bits 6 and 5 are given zero here
    // ------------------------------------------------------------
    localparam logic [7:0] PMC_PC_RESET   = 8'h00;
    localparam logic [7:0] PMC_AUX_RESET  = 8'h00;
    localparam logic [7:0] PMC_AUX1_RESET = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PMC_CLK_NS          = 8;   // pclk period in ns
    localparam int PMC_OSC_PER_MC      = 12;  // oscillator periods per machine cycle
    localparam int PMC_IDLE_RST_MC     = 2;   // machine cycles of ram block on idle reset
    localparam int PMC_IDLE_RST_CYCLES = PMC_IDLE_RST_MC * PMC_OSC_PER_MC;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMC_NORMAL,
        PMC_IDLE,
        PMC_POWERDOWN,
        PMC_EMULATION
    } pmc_mode_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } pmc_apb_req_t;

    typedef struct packed {
        logic ale_oe_n;        // ale output enable, low drives
        logic ale_out;         // ale level when driven
        logic prog_store_strobe_oe_n;       // program store strobe enable, low drives
        logic port0_float;     // port 0 released
        logic ports_weak_hi;   // other ports weak pull up
    } pmc_pin_ctl_t;

endpackage : pmc_pkg

// ===== rtl/pmc_apb_slave.sv
// apb slave front end: decodes a transfer into one-cycle write and read strobes
`timescale 1ns/1ps
module pmc_apb_slave (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire pmc_pkg::pmc_apb_req_t req,
    output logic                       wr_stb,
    output logic                       rd_stb,
    output logic                       pready,
    output logic [11:0]                addr,
    output logic [31:0]                wdata
);
    import pmc_pkg::*;

    logic ready_reg;   // one wait state then ready
    logic ready_next;

    // ------------------------------------------------------------
    // access phase timing
    // ------------------------------------------------------------
    // ready rises in the second access cycle so read data is registered
    always_comb begin
        ready_next = req.psel && req.penable && !ready_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    assign pready = ready_reg;
    // write strobe fires on the completing edge, read strobe one edge earlier in the wait cycle
    assign wr_stb = req.psel && req.penable && ready_reg && req.pwrite;
    assign rd_stb = req.psel && req.penable && !ready_reg && !req.pwrite;
    assign addr   = req.paddr;
    assign wdata  = req.pwdata;

endmodule : pmc_apb_slave

// ===== rtl/pmc_cycle_timer.sv
// down counter that holds a level for a fixed number of clock cycles after a start pulse
`timescale 1ns/1ps
module pmc_cycle_timer #(
    parameter int CYCLES = 24
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    output logic      busy
);
    import pmc_pkg::*;

    localparam logic [7:0] LOAD = 8'(CYCLES);  // count loaded at start

    logic [7:0] cnt_reg;   // remaining cycles
    logic [7:0] cnt_next;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        if (start) begin
            cnt_next = LOAD;
        end else if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign busy = (cnt_reg != 8'h00);

endmodule : pmc_cycle_timer

// ===== rtl/pmc_power_mode_control.sv
// power control register, idle and powerdown mode logic, emulation entry and ale suppression
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module pmc_power_mode_control #(
    parameter int IDLE_RST_CYCLES = pmc_pkg::PMC_IDLE_RST_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  power_on_detect,
    input  wire logic                  idle_hw_reset,
    input  wire logic                  irq_enabled,
    input  wire logic                  ext_irq,
    input  wire logic                  ext_mem_access,
    input  wire logic                  ale_core,
    input  wire logic                  ale_pin_in,
    input  wire logic                  prog_store_strobe_in,
    input  wire logic                  ram_req,
    input  wire logic [1:0]            serial_mode,
    input  wire pmc_pkg::pmc_apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       ram_grant,
    output logic                       osc_run,
    output logic                       cpu_sleep,
    output logic                       baud_x2,
    output logic                       scon7_is_frame_error,
    output logic                       general_flag_1,
    output logic                       general_flag_0,
    output pmc_pkg::pmc_pin_ctl_t      pin_ctl
);
    import pmc_pkg::*;

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    logic        wr_stb;   // write completes this edge
    logic        rd_stb;   // read data captured this edge
    logic        bus_ready;
    logic [11:0] addr;
    logic [31:0] wdata;

    pmc_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (apb_req),
        .wr_stb  (wr_stb),
        .rd_stb  (rd_stb),
        .pready  (bus_ready),
        .addr    (addr),
        .wdata   (wdata)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]   pc_reg, pc_next;        // power control
    logic [7:0]   aux_reg, aux_next;      // aux register
    logic [7:0]   aux1_reg, aux1_next;    // aux register 1
    pmc_mode_t    mode_reg, mode_next;    // operating mode
    logic         emu_arm_reg, emu_arm_next; // set by reset, ale sampled in first cycle
    logic         first_reg, first_next;  // first cycle after release
    logic [31:0]  rdata_reg, rdata_next;  // registered read data
    logic         err_reg, err_next;      // unmapped access
    logic         ram_block;              // idle reset window
    logic         idle_rst_start;

    // decoded writes
    logic wr_pc, wr_aux, wr_aux1, wr_ev, mapped;
    assign wr_pc   = wr_stb && (addr == PMC_OFF_POWER_CONTROL);
    assign wr_aux  = wr_stb && (addr == PMC_OFF_AUX_REGISTER);
    assign wr_aux1 = wr_stb && (addr == PMC_OFF_AUX_REGISTER1);
    assign wr_ev   = wr_stb && (addr == PMC_OFF_EVENTS);
    assign mapped  = (addr == PMC_OFF_POWER_CONTROL) || (addr == PMC_OFF_AUX_REGISTER)
                  || (addr == PMC_OFF_AUX_REGISTER1) || (addr == PMC_OFF_EVENTS)
                  || (addr == PMC_OFF_STATUS);

    logic wdt_loaded;   // watchdog timer load event
    assign wdt_loaded = wr_ev && wdata[PMC_EV_WDT_LOAD];

    // mode exits from registered state only, so pc_next and mode_next form no loop
    logic idle_exit;   // idle left at this edge
    logic pd_exit;     // powerdown left at this edge
    assign idle_exit = !first_reg && (mode_reg == PMC_IDLE) && (irq_enabled || idle_hw_reset);
    assign pd_exit   = !first_reg && (mode_reg == PMC_POWERDOWN) && ext_irq
                    && aux1_reg[PMC_AUX1_POWERDOWN_WAKEUP_ENABLE];

    // ------------------------------------------------------------
    // idle reset ram block window
    // ------------------------------------------------------------
    // ports stay accessible; only ram is gated during the window
    assign idle_rst_start = idle_hw_reset && (mode_reg == PMC_IDLE);

    pmc_cycle_timer #(
        .CYCLES (IDLE_RST_CYCLES)
    ) u_idle_rst (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (idle_rst_start),
        .busy    (ram_block)
    );

    // ------------------------------------------------------------
    // power control next value
    // ------------------------------------------------------------
    always_comb begin
        pc_next = pc_reg;
        if (wr_pc) begin
            pc_next = wdata[7:0];
            // powerdown write of 1 dropped while watchdog runs
            if (aux1_reg[PMC_AUX1_WDE]) begin
                pc_next[PMC_PC_PD] = pc_reg[PMC_PC_PD];
            end
            // powerdown wins, idle select kept low
            if (pc_next[PMC_PC_PD]) begin
                pc_next[PMC_PC_IDL] = 1'b0;
            end
        end
        // hardware load clears enable; takes priority over the write
        if (wdt_loaded) begin
            pc_next[PMC_PC_WLE] = 1'b0;
        end
        // select bits fall when the mode is left
        if (idle_exit) begin
            pc_next[PMC_PC_IDL] = 1'b0;
        end
        if (pd_exit) begin
            pc_next[PMC_PC_PD] = 1'b0;
        end
        // power on detect is a set, wins over software clear
        if (power_on_detect) begin
            pc_next[PMC_PC_POF] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // aux registers
    // ------------------------------------------------------------
    always_comb begin
        aux_next  = wr_aux  ? wdata[7:0] : aux_reg;
        aux1_next = wr_aux1 ? wdata[7:0] : aux1_reg;
    end

    // ------------------------------------------------------------
    // mode machine
    // ------------------------------------------------------------
    always_comb begin
        mode_next    = mode_reg;
        emu_arm_next = 1'b0;
        first_next   = 1'b0;
        if (first_reg) begin
            // ale still low at release with prog_store_strobe high enters emulation
            if (emu_arm_reg && !ale_pin_in && prog_store_strobe_in) begin
                mode_next = PMC_EMULATION;
            end
        end else begin
            unique case (mode_reg)
                PMC_NORMAL: begin
                    if (pc_next[PMC_PC_PD]) begin
                        mode_next = PMC_POWERDOWN;
                    end else if (pc_next[PMC_PC_IDL]) begin
                        mode_next = PMC_IDLE;
                    end
                end
                PMC_IDLE: begin
                    if (irq_enabled || idle_hw_reset) begin
                        mode_next = PMC_NORMAL;
                    end
                end
                PMC_POWERDOWN: begin
                    if (ext_irq && aux1_reg[PMC_AUX1_POWERDOWN_WAKEUP_ENABLE]) begin
                        mode_next = PMC_NORMAL;
                    end
                end
                PMC_EMULATION: begin
                    mode_next = PMC_EMULATION;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read mux and error
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        err_next   = 1'b0;
        if (rd_stb) begin
            rdata_next = 32'h0000_0000;
            unique case (addr)
                PMC_OFF_POWER_CONTROL: rdata_next[7:0] = pc_reg;
                PMC_OFF_AUX_REGISTER:  rdata_next[7:0] = aux_reg;
                PMC_OFF_AUX_REGISTER1: rdata_next[7:0] = aux1_reg;
                PMC_OFF_STATUS: begin
                    rdata_next[1:0] = mode_reg;
                    rdata_next[2]   = ram_block;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if ((rd_stb || (apb_req.psel && apb_req.penable && !bus_ready)) && !mapped) begin
            err_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state registers; emulation arm set by reset, cleared at the first edge after release
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg      <= PMC_PC_RESET;
            aux_reg     <= PMC_AUX_RESET;
            aux1_reg    <= PMC_AUX1_RESET;
            mode_reg    <= PMC_NORMAL;
            emu_arm_reg <= 1'b1;
            first_reg   <= 1'b1;
            rdata_reg   <= 32'h0000_0000;
            err_reg     <= 1'b0;
        end else begin
            pc_reg      <= pc_next;
            aux_reg     <= aux_next;
            aux1_reg    <= aux1_next;
            mode_reg    <= mode_next;
            emu_arm_reg <= emu_arm_next;
            first_reg   <= first_next;
            rdata_reg   <= rdata_next;
            err_reg     <= err_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    pmc_pin_ctl_t pin_next;
    logic         ram_grant_next, osc_next, sleep_next, baud_next, fe_next;

    always_comb begin
        pin_next = '0;
        if (mode_next == PMC_EMULATION) begin
            pin_next.port0_float   = 1'b1;
            pin_next.ports_weak_hi = 1'b1;
            pin_next.ale_oe_n      = 1'b1;
            pin_next.prog_store_strobe_oe_n     = 1'b1;
        end else begin
            // ale released when off bit set unless external access runs
            pin_next.ale_oe_n = aux_next[PMC_AUX_ALE_OFF] && !ext_mem_access;
            pin_next.ale_out  = ale_core;
        end
        ram_grant_next = ram_req && !ram_block;
        osc_next       = (mode_next != PMC_POWERDOWN);
        sleep_next     = (mode_next == PMC_IDLE) || (mode_next == PMC_POWERDOWN);
        // doubling applies in serial modes 1, 2 and 3 only
        baud_next      = pc_next[PMC_PC_BAUD_DOUBLE] && (serial_mode != 2'b00);
        fe_next        = pc_next[PMC_PC_FRAME_SEL];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ctl              <= '0;
            ram_grant            <= 1'b0;
            osc_run              <= 1'b1;
            cpu_sleep            <= 1'b0;
            baud_x2              <= 1'b0;
            scon7_is_frame_error <= 1'b0;
            general_flag_1       <= 1'b0;
            general_flag_0       <= 1'b0;
        end else begin
            pin_ctl              <= pin_next;
            ram_grant            <= ram_grant_next;
            osc_run              <= osc_next;
            cpu_sleep            <= sleep_next;
            baud_x2              <= baud_next;
            scon7_is_frame_error <= fe_next;
            general_flag_1       <= pc_next[PMC_PC_GF1];
            general_flag_0       <= pc_next[PMC_PC_GF0];
        end
    end

    assign prdata  = rdata_reg;
    assign pready  = bus_ready;
    assign pslverr = err_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_POF_SET: assert property (@(posedge pclk) disable iff (!presetn)
        power_on_detect |=> pc_reg[PMC_PC_POF])
        else $error("power off flag not set after power on");
    AST_PD_WDE: assert property (@(posedge pclk) disable iff (!presetn)
        (aux1_reg[PMC_AUX1_WDE] && !pc_reg[PMC_PC_PD]) |=> !pc_reg[PMC_PC_PD])
        else $error("powerdown set while watchdog enabled");
    AST_PD_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_reg == PMC_NORMAL && !first_reg && pc_next[PMC_PC_PD]) |=> mode_reg == PMC_POWERDOWN)
        else $error("powerdown not taken");
    AST_WLE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
        wdt_loaded |=> !pc_reg[PMC_PC_WLE])
        else $error("load enable not cleared");
    AST_RAM_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        idle_rst_start |=> ##1 !ram_grant [*8])
        else $error("ram granted during idle reset window");
    AST_EMU_STAY: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == PMC_EMULATION |=> mode_reg == PMC_EMULATION)
        else $error("emulation left without reset");
    AST_ALE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (aux_reg[PMC_AUX_ALE_OFF] && !ext_mem_access && mode_reg != PMC_EMULATION)
        |=> pin_ctl.ale_oe_n)
        else $error("ale driven while off");
    AST_OSC_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mode_reg == PMC_POWERDOWN) |-> !osc_run)
        else $error("oscillator runs in powerdown");
    AST_IDLE_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_reg == PMC_IDLE && irq_enabled && !first_reg)
        |=> mode_reg == PMC_NORMAL ##0 !pc_reg[PMC_PC_IDL])
        else $error("idle not left on interrupt");

endmodule : pmc_power_mode_control

// ===== bench/pmc_core_model.sv
// processor core side model: apb master for the power control registers
`timescale 1ns/1ps
module pmc_core_model (
    input  wire logic                  pclk,
    input  wire logic                  pready,
    input  wire logic [31:0]           prdata,
    input  wire logic                  pslverr,
    output pmc_pkg::pmc_apb_req_t      req
);
    import pmc_pkg::*;
    initial req = '0;  // idle bus at time zero
    // one transfer, held until pready is seen high; hung flags a lost answer
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic hung);
        int n;
        n = 0;
        req <= '{a, 1'b1, 1'b0, wr, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        hung = (n >= 16);
        // released data is inverted so a stale copy is never read as valid
        req <= '{a, 1'b0, 1'b0, 1'b0, ~d};
        @(posedge pclk);
    endtask : xfer
endmodule : pmc_core_model

// ===== bench/pmc_power_mode_control_tb_top.sv
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module pmc_power_mode_control_tb_top;
    import pmc_pkg::*;
    // ----
    // signals
    // ----
    logic pclk, presetn, pod, ihr, irq, eirq, ema, ale_c, ale_p, prog_store_strobe_p, ram_req;
    logic [1:0] smode;
    logic [31:0] prdata, q, d;
    logic pready, pslverr, grant, osc, sleep, bx2, fe, gf1, gf0, e;
    pmc_apb_req_t apb;
    pmc_pin_ctl_t pin;
    int errors, cmp_count, seed, n;
    // eight cycles keep the idle reset window short yet as long as its assertion's span
    pmc_power_mode_control #(.IDLE_RST_CYCLES(8)) DUT (.pclk(pclk), .presetn(presetn),
        .power_on_detect(pod), .idle_hw_reset(ihr), .irq_enabled(irq), .ext_irq(eirq),
        .ext_mem_access(ema), .ale_core(ale_c), .ale_pin_in(ale_p),
        .prog_store_strobe_in(prog_store_strobe_p), .ram_req(ram_req), .serial_mode(smode),
        .apb_req(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ram_grant(grant), .osc_run(osc), .cpu_sleep(sleep), .baud_x2(bx2),
        .scon7_is_frame_error(fe), .general_flag_1(gf1), .general_flag_0(gf0),
        .pin_ctl(pin));
    pmc_core_model u_core (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .req(apb));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ----
    // helpers
    // ----
    function automatic logic exp_baud(input logic [31:0] v, input logic [1:0] m);
        return v[7] && (m != 2'h0);  // mode 0 has no doubling
    endfunction : exp_baud
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v);
        logic h;
        u_core.xfer(w, a, v, q, e, h);
        if (h) begin
            errors++;
            summarize();
        end
    endtask : acc
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    // strap level on the address latch pin is held through release
    task automatic rst(input logic ale);
        ale_p <= ale;
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(2);
        ale_p <= 1'b1;
    endtask : rst
    // ----
    // scenarios
    // ----
    initial begin
        seed = 32'h88b6d1c5;
        {pod, ihr, irq, eirq, ema, ale_c, ram_req, smode, presetn} = '0;
        {ale_p, prog_store_strobe_p} = 2'h3;
        rst(1'b1);
        rd(PMC_OFF_POWER_CONTROL, 32'h0);
        acc(1'b0, 12'h0a0, 32'h0);
        chk(e, 32'h1);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 32'hcc : ($random(seed) & 32'hcc);
            smode <= 2'($random(seed));
            acc(1'b1, PMC_OFF_POWER_CONTROL, d);
            rd(PMC_OFF_POWER_CONTROL, d);
            chk(bx2, exp_baud(d, smode));
            chk(fe, d[6]);
            chk({gf1, gf0}, d[3:2]);
        end
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h20);
        rd(PMC_OFF_POWER_CONTROL, 32'h20);
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h0);
        rd(PMC_OFF_POWER_CONTROL, 32'h0);
        pod <= 1'b1;
        cyc(1);
        pod <= 1'b0;
        rd(PMC_OFF_POWER_CONTROL, 32'h20);
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h10);
        rd(PMC_OFF_POWER_CONTROL, 32'h10);
        acc(1'b1, PMC_OFF_EVENTS, 32'h1);
        rd(PMC_OFF_POWER_CONTROL, 32'h0);
        acc(1'b1, PMC_OFF_AUX_REGISTER1, 32'h18);
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h2);
        rd(PMC_OFF_POWER_CONTROL, 32'h0);
        acc(1'b1, PMC_OFF_AUX_REGISTER1, 32'h0);
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h3);
        eirq <= 1'b1;
        cyc(4);
        chk({osc, sleep}, 32'h1);
        rd(PMC_OFF_POWER_CONTROL, 32'h2);
        eirq <= 1'b0;
        rst(1'b1);
        chk(osc, 32'h1);
        acc(1'b1, PMC_OFF_AUX_REGISTER1, 32'h8);
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h2);
        eirq <= 1'b1;
        for (n = 0; n < 12 && osc !== 1'b1; n++) cyc(1);
        chk(osc, 32'h1);
        eirq <= 1'b0;
        rd(PMC_OFF_POWER_CONTROL, 32'h0);
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h1);
        chk({osc, sleep}, 32'h3);
        irq <= 1'b1;
        for (n = 0; n < 12 && sleep !== 1'b0; n++) cyc(1);
        chk(sleep, 32'h0);
        irq <= 1'b0;
        rd(PMC_OFF_POWER_CONTROL, 32'h0);
        ram_req <= 1'b1;
        acc(1'b1, PMC_OFF_POWER_CONTROL, 32'h1);
        ihr <= 1'b1;
        cyc(1);
        ihr <= 1'b0;
        cyc(3);
        chk(grant, 32'h0);
        cyc(8);
        chk({grant, sleep}, 32'h2);
        acc(1'b1, PMC_OFF_AUX_REGISTER, 32'h1);
        ale_c <= 1'b1;
        cyc(3);
        chk(pin.ale_out & ~pin.ale_oe_n, 32'h0);
        ema <= 1'b1;
        cyc(3);
        chk(pin.ale_out & ~pin.ale_oe_n, 32'h1);
        ema <= 1'b0;
        cyc(3);
        chk(pin.ale_out & ~pin.ale_oe_n, 32'h0);
        rst(1'b0);
        cyc(4);
        chk({pin.port0_float, pin.ports_weak_hi, pin.ale_oe_n, pin.prog_store_strobe_oe_n, osc}, 32'h1f);
        rst(1'b1);
        chk(pin.port0_float, 32'h0);
        // strobe low during reset must not enter emulation
        prog_store_strobe_p <= 1'b0;
        rst(1'b0);
        chk(pin.port0_float, 32'h0);
        summarize();
    end
endmodule : pmc_power_mode_control_tb_top
